// ---- shared/eel_pkg.sv ----
// Package with register map, field layout and types of the ECC error log
// Notes on behaviour
// - Single error on bit n<32 sets low map bit n
// - Single error on bit 32+n sets high map bit n
// - Map writes clear ones, ignore zeros
// - Two-deep FIFO logs single error burst addresses
// - Writing 0x1 pops the oldest FIFO entry
// - Writing 0x2 pops both; other values ignored
// - First double error burst address is captured
// - Writing 0x1 clears double log; others ignored
// - Count above nonzero threshold raises interrupt
package eel_pkg;

    localparam int EEL_ADDR_W = 8;
    localparam int EEL_DATA_W = 32;
    localparam int EEL_STRB_W = 4;

    localparam logic [7:0] EEL_OFF_ERR_COUNT = 8'h00;
    localparam logic [7:0] EEL_OFF_THRESHOLD = 8'h04;
    localparam logic [7:0] EEL_OFF_MAP_LOW = 8'h08;
    localparam logic [7:0] EEL_OFF_ADDR_FIFO = 8'h0c;
    localparam logic [7:0] EEL_OFF_DBL_ADDR = 8'h10;
    localparam logic [7:0] EEL_OFF_MAP_HIGH = 8'h14;
    localparam logic [7:0] EEL_OFF_IRQ_STATUS = 8'h18;
    localparam logic [7:0] EEL_OFF_IRQ_MASK = 8'h1c;

    localparam int EEL_THR_LSB = 24;
    localparam int EEL_THR_W = 8;

    localparam logic [31:0] EEL_POP_ONE = 32'h0000_0001;
    localparam logic [31:0] EEL_POP_BOTH = 32'h0000_0002;
    localparam logic [31:0] EEL_DBL_CLEAR = 32'h0000_0001;

    localparam logic [1:0] EEL_FIFO_DEPTH = 2'h2;

    localparam int EEL_IRQ_W = 3;
    localparam int EEL_IRQ_SINGLE = 0;
    localparam int EEL_IRQ_DOUBLE = 1;
    localparam int EEL_IRQ_THRESH = 2;

    localparam logic [31:0] EEL_RST_WORD = 32'h0000_0000;
    localparam logic [7:0] EEL_RST_THR = 8'h00;
    localparam logic [2:0] EEL_RST_IRQ = 3'h0;

    localparam logic [1:0] EEL_RESP_OKAY = 2'h0;
    localparam logic [1:0] EEL_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic singleErr;
        logic doubleErr;
        logic [63:0] errBits;
        logic [31:0] burstAddr;
    } eel_report_s;

    typedef enum {
        SEL_COUNT,
        SEL_THRESH,
        SEL_MAP_LOW,
        SEL_ADDR_FIFO,
        SEL_DBL_ADDR,
        SEL_MAP_HIGH,
        SEL_IRQ_STATUS,
        SEL_IRQ_MASK,
        SEL_NONE
    } eel_sel_e;

endpackage

// ---- hw/eel_error_log.sv ----
// ECC error log: bit maps, address FIFO, double error log, AXI4-Lite slave
`timescale 1ns/1ns
module eel_error_log (
    input wire logic clk,
    input wire logic nrst,
    input wire eel_pkg::eel_report_s report,
    input wire logic [eel_pkg::EEL_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [eel_pkg::EEL_DATA_W-1:0] wdata,
    input wire logic [eel_pkg::EEL_STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [eel_pkg::EEL_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [eel_pkg::EEL_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq
);
    import eel_pkg::*;

    function automatic eel_sel_e decodeSel(input logic [EEL_ADDR_W-1:0] a);
        logic [EEL_ADDR_W-1:0] w;
        w = {a[EEL_ADDR_W-1:2], 2'h0};
        if (w == EEL_OFF_ERR_COUNT) begin
            decodeSel = SEL_COUNT;
        end else if (w == EEL_OFF_THRESHOLD) begin
            decodeSel = SEL_THRESH;
        end else if (w == EEL_OFF_MAP_LOW) begin
            decodeSel = SEL_MAP_LOW;
        end else if (w == EEL_OFF_ADDR_FIFO) begin
            decodeSel = SEL_ADDR_FIFO;
        end else if (w == EEL_OFF_DBL_ADDR) begin
            decodeSel = SEL_DBL_ADDR;
        end else if (w == EEL_OFF_MAP_HIGH) begin
            decodeSel = SEL_MAP_HIGH;
        end else if (w == EEL_OFF_IRQ_STATUS) begin
            decodeSel = SEL_IRQ_STATUS;
        end else if (w == EEL_OFF_IRQ_MASK) begin
            decodeSel = SEL_IRQ_MASK;
        end else begin
            decodeSel = SEL_NONE;
        end
    endfunction

    // Bus side state
    logic awreadyReg;
    logic wreadyReg;
    logic bvalidReg;
    logic [1:0] brespReg;
    logic arreadyReg;
    logic rvalidReg;
    logic [1:0] rrespReg;
    logic [31:0] rdataReg;
    logic awHaveReg;
    logic wHaveReg;
    logic [EEL_ADDR_W-1:0] awAddrReg;
    logic [31:0] wDataReg;
    logic [3:0] wStrbReg;

    // Logging state
    logic [31:0] countReg;
    logic [7:0] thrReg;
    logic [31:0] mapLowReg;
    logic [31:0] mapHighReg;
    logic [31:0] slot0Reg;
    logic [31:0] slot1Reg;
    logic [1:0] fillReg;
    logic dblValidReg;
    logic [31:0] dblAddrReg;
    logic [EEL_IRQ_W-1:0] statusReg;
    logic [EEL_IRQ_W-1:0] maskReg;
    logic overReg;
    logic irqReg;

    // Write path decode
    wire awFire = awvalid && awreadyReg;
    wire wFire = wvalid && wreadyReg;
    wire doWrite = awHaveReg && wHaveReg && !bvalidReg;
    eel_sel_e wrSel;
    assign wrSel = decodeSel(awAddrReg);
    wire [31:0] byteMask = {{8{wStrbReg[3]}}, {8{wStrbReg[2]}},
                            {8{wStrbReg[1]}}, {8{wStrbReg[0]}}};
    // Unwritten byte lanes count as zero, so a partial write of a code
    // only acts when the written lanes alone form that code
    wire [31:0] wrData = wDataReg & byteMask;
    wire wrCount = doWrite && (wrSel == SEL_COUNT);
    wire wrThresh = doWrite && (wrSel == SEL_THRESH) && wStrbReg[3];
    wire wrMapLow = doWrite && (wrSel == SEL_MAP_LOW);
    wire wrFifo = doWrite && (wrSel == SEL_ADDR_FIFO);
    wire wrDbl = doWrite && (wrSel == SEL_DBL_ADDR);
    wire wrMapHigh = doWrite && (wrSel == SEL_MAP_HIGH);
    wire wrMask = doWrite && (wrSel == SEL_IRQ_MASK);
    wire [1:0] wrResp = (wrSel == SEL_NONE) ? EEL_RESP_SLVERR : EEL_RESP_OKAY;

    // Read path decode
    wire arFire = arvalid && arreadyReg;
    eel_sel_e rdSel;
    assign rdSel = decodeSel(araddr);
    wire rdStatus = arFire && (rdSel == SEL_IRQ_STATUS);
    wire [31:0] fifoHead = (fillReg != 2'h0) ? slot0Reg : EEL_RST_WORD;
    wire [31:0] thrWord = {thrReg, 24'h00_0000};
    wire [31:0] statusWord = {29'h0000_0000, statusReg};
    wire [31:0] maskWord = {29'h0000_0000, maskReg};
    wire [31:0] rdMux = (rdSel == SEL_COUNT) ? countReg :
                        (rdSel == SEL_THRESH) ? thrWord :
                        (rdSel == SEL_MAP_LOW) ? mapLowReg :
                        (rdSel == SEL_ADDR_FIFO) ? fifoHead :
                        (rdSel == SEL_DBL_ADDR) ? dblAddrReg :
                        (rdSel == SEL_MAP_HIGH) ? mapHighReg :
                        (rdSel == SEL_IRQ_STATUS) ? statusWord :
                        (rdSel == SEL_IRQ_MASK) ? maskWord :
                        EEL_RST_WORD;
    wire [1:0] rdResp = (rdSel == SEL_NONE) ? EEL_RESP_SLVERR : EEL_RESP_OKAY;

    // Distribution maps: a new error wins over a clear of the same bit
    wire [31:0] setLow = report.singleErr ? report.errBits[31:0] : 32'h0;
    wire [31:0] setHigh = report.singleErr ? report.errBits[63:32] : 32'h0;
    wire [31:0] clrLow = wrMapLow ? wrData : 32'h0;
    wire [31:0] clrHigh = wrMapHigh ? wrData : 32'h0;
    wire [31:0] mapLowNext = (mapLowReg & ~clrLow) | setLow;
    wire [31:0] mapHighNext = (mapHighReg & ~clrHigh) | setHigh;

    // Address FIFO: pop first, then push into the room the pop made
    wire popOne = wrFifo && (wrData == EEL_POP_ONE);
    wire popBoth = wrFifo && (wrData == EEL_POP_BOTH);
    wire [1:0] fillAfterPop = popBoth ? 2'h0 :
                              (popOne && fillReg != 2'h0) ?
                              fillReg - 2'h1 : fillReg;
    wire [31:0] headAfterPop = popOne ? slot1Reg : slot0Reg;
    wire pushOk = report.singleErr && (fillAfterPop != EEL_FIFO_DEPTH);
    wire [31:0] slot0Next = (pushOk && fillAfterPop == 2'h0) ?
                            report.burstAddr : headAfterPop;
    wire [31:0] slot1Next = (pushOk && fillAfterPop == 2'h1) ?
                            report.burstAddr : slot1Reg;
    wire [1:0] fillNext = fillAfterPop + {1'b0, pushOk};

    // Double error log holds the first address until cleared
    wire dblClear = wrDbl && (wrData == EEL_DBL_CLEAR);
    wire dblCapture = report.doubleErr && (!dblValidReg || dblClear);
    wire dblValidNext = dblCapture || (dblValidReg && !dblClear);
    wire [31:0] dblAddrNext = dblCapture ? report.burstAddr :
                              dblClear ? EEL_RST_WORD : dblAddrReg;

    // Error counter saturates both ways so software cannot wrap it
    wire [32:0] countInc = {1'b0, countReg} + {32'h0, report.singleErr};
    wire [32:0] countSub = wrCount ? {1'b0, wrData} : 33'h0;
    wire [31:0] countNext = (countSub > countInc) ? 32'h0 :
                            (countInc - countSub > 33'h0_ffff_ffff) ?
                            32'hffff_ffff :
                            32'(countInc - countSub);
    wire [7:0] thrNext = wrThresh ? wrData[EEL_THR_LSB +: EEL_THR_W] : thrReg;
    // Threshold zero means no threshold interrupt at all
    wire overNext = (thrNext != EEL_RST_THR) &&
                    (countNext > {24'h00_0000, thrNext});

    // Status: events set, a read of the register clears, set wins
    wire [EEL_IRQ_W-1:0] events = {overNext && !overReg,
                                   report.doubleErr,
                                   report.singleErr};
    wire [EEL_IRQ_W-1:0] statusClr = rdStatus ? {EEL_IRQ_W{1'b1}} : EEL_RST_IRQ;
    wire [EEL_IRQ_W-1:0] statusNext = (statusReg & ~statusClr) | events;
    wire [EEL_IRQ_W-1:0] maskNext = wrMask ? wrData[EEL_IRQ_W-1:0] : maskReg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            awreadyReg <= 1'b0;
            wreadyReg <= 1'b0;
            awHaveReg <= 1'b0;
            wHaveReg <= 1'b0;
            awAddrReg <= '0;
            wDataReg <= EEL_RST_WORD;
            wStrbReg <= 4'h0;
        end else begin
            if (awFire) begin
                awAddrReg <= awaddr;
                awHaveReg <= 1'b1;
                awreadyReg <= 1'b0;
            end else if (doWrite) begin
                awHaveReg <= 1'b0;
            end else if (!awHaveReg && !bvalidReg) begin
                awreadyReg <= 1'b1;
            end
            if (wFire) begin
                wDataReg <= wdata;
                wStrbReg <= wstrb;
                wHaveReg <= 1'b1;
                wreadyReg <= 1'b0;
            end else if (doWrite) begin
                wHaveReg <= 1'b0;
            end else if (!wHaveReg && !bvalidReg) begin
                wreadyReg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bvalidReg <= 1'b0;
            brespReg <= EEL_RESP_OKAY;
        end else if (doWrite) begin
            bvalidReg <= 1'b1;
            brespReg <= wrResp;
        end else if (bvalidReg && bready) begin
            bvalidReg <= 1'b0;
        end
    end

    // One read at a time; the answer stands one cycle after acceptance
    always_ff @(posedge clk) begin
        if (!nrst) begin
            arreadyReg <= 1'b0;
            rvalidReg <= 1'b0;
            rrespReg <= EEL_RESP_OKAY;
            rdataReg <= EEL_RST_WORD;
        end else if (arFire) begin
            arreadyReg <= 1'b0;
            rvalidReg <= 1'b1;
            rrespReg <= rdResp;
            rdataReg <= rdMux;
        end else if (rvalidReg && rready) begin
            rvalidReg <= 1'b0;
        end else if (!rvalidReg) begin
            arreadyReg <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mapLowReg <= EEL_RST_WORD;
            mapHighReg <= EEL_RST_WORD;
        end else begin
            mapLowReg <= mapLowNext;
            mapHighReg <= mapHighNext;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            slot0Reg <= EEL_RST_WORD;
            slot1Reg <= EEL_RST_WORD;
            fillReg <= 2'h0;
        end else begin
            slot0Reg <= slot0Next;
            slot1Reg <= slot1Next;
            fillReg <= fillNext;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            dblValidReg <= 1'b0;
            dblAddrReg <= EEL_RST_WORD;
        end else begin
            dblValidReg <= dblValidNext;
            dblAddrReg <= dblAddrNext;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            countReg <= EEL_RST_WORD;
            thrReg <= EEL_RST_THR;
            overReg <= 1'b0;
        end else begin
            countReg <= countNext;
            thrReg <= thrNext;
            overReg <= overNext;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            statusReg <= EEL_RST_IRQ;
            maskReg <= EEL_RST_IRQ;
            irqReg <= 1'b0;
        end else begin
            statusReg <= statusNext;
            maskReg <= maskNext;
            irqReg <= |(statusNext & maskNext);
        end
    end

    assign awready = awreadyReg;
    assign wready = wreadyReg;
    assign bvalid = bvalidReg;
    assign bresp = brespReg;
    assign arready = arreadyReg;
    assign rvalid = rvalidReg;
    assign rresp = rrespReg;
    assign rdata = rdataReg;
    assign irq = irqReg;

endmodule

// ---- dv/eel_log_properties.sv ----
// Checker of the register bus behaviour of the ECC error log
`timescale 1ns/1ns
module eel_log_checker
    import eel_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire eel_pkg::eel_report_s report,
    input wire logic [eel_pkg::EEL_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [eel_pkg::EEL_DATA_W-1:0] wdata,
    input wire logic [eel_pkg::EEL_STRB_W-1:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [eel_pkg::EEL_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [eel_pkg::EEL_DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_wr;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_rd;
        arvalid && arready;
    endsequence
    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bresp not held");
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rdata not held");
    property p_b_due;
        s_wr |-> ##[1:2] bvalid;
    endproperty
    a_b_due: assert property (p_b_due) else $error("no write answer");
    property p_r_due;
        s_rd |-> ##[1:2] rvalid;
    endproperty
    a_r_due: assert property (p_r_due) else $error("no read answer");
    property p_wr_unmapped;
        s_wr ##0 (awaddr[7:5] != 3'h0) |-> ##[1:2] (bvalid && bresp == 2'h2);
    endproperty
    a_wr_unmapped: assert property (p_wr_unmapped)
        else $error("unmapped write not refused");
    property p_rd_unmapped;
        s_rd ##0 (araddr[7:5] != 3'h0) |->
            ##[1:2] (rvalid && rresp == 2'h2 && rdata == 32'h0);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not refused");
    property p_one_wr;
        bvalid |-> !awready && !wready;
    endproperty
    a_one_wr: assert property (p_one_wr) else $error("second write taken");
    property p_one_rd;
        rvalid |-> !arready;
    endproperty
    a_one_rd: assert property (p_one_rd) else $error("second read taken");
endmodule
bind eel_error_log eel_log_checker u_chk (.clk(clk), .nrst(nrst),
    .report(report), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irq(irq));

// ---- dv/tb_top.sv ----
// Testbench of the ECC error log with a queue based reference model
`timescale 1ns/1ns
module tb_top;
    import eel_pkg::*;
    logic clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, dblV;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed, mapLo, mapHi, dbl, cnt, rd, rnd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    eel_report_s report;
    logic [31:0] fifo[$];
    int n_mismatch, comparisons;
    eel_error_log uut (.clk(clk), .nrst(nrst), .report(report),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        int t;
        t = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Each channel is released on the edge that takes it
        do begin
            @(posedge clk);
            t++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && t < 100);
        bready <= 1'b0;
        chk("bvalid", {31'h0, bvalid}, 32'h1);
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rdx(input logic [7:0] a);
        int t;
        t = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            t++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && t < 100);
        rready <= 1'b0;
        chk("rvalid", {31'h0, rvalid}, 32'h1);
        rd = rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rdx(a);
        chk("rdata", rd, e);
        chk("rresp", {30'h0, rresp}, 32'h0);
    endtask
    task automatic rep(input logic s, d, input logic [63:0] b,
        input logic [31:0] a);
        @(posedge clk);
        report <= '{s, d, b, a};
        @(posedge clk);
        report <= '0;
        if (s) begin
            mapLo |= b[31:0];
            mapHi |= b[63:32];
            cnt++;
            if (fifo.size() < 2) fifo.push_back(a);
        end
        if (d && !dblV) begin
            dbl = a;
            dblV = 1'b1;
        end
    endtask
    task automatic irqc(input logic e);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0, irq}, {31'h0, e});
    endtask
    function automatic logic [31:0] head();
        return fifo.size() ? fifo[0] : 32'h0;
    endfunction
    task automatic wrap_up();
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        seed = 32'h34989559;
        {nrst, awvalid, wvalid, bready, arvalid, rready, dblV} = 7'h0;
        {awaddr, araddr, wdata, mapLo, mapHi, dbl, cnt} = '0;
        wstrb = 4'hf;
        report = '0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 2; i < 6; i++) rdc(8'(i * 4), 32'h0);
        rdx(8'h20);
        chk("unmapped", {rd[29:0], rresp}, 32'h2);
        wr(8'h20, 32'h0, EEL_RESP_SLVERR);
        wr(EEL_OFF_IRQ_MASK, 32'h4, EEL_RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            rnd = xs();
            rep(1'b1, 1'b0, 64'h1 << rnd[5:0], xs());
        end
        irqc(1'b0);
        rdc(EEL_OFF_MAP_LOW, mapLo);
        rdc(EEL_OFF_MAP_HIGH, mapHi);
        rnd = xs();
        wr(EEL_OFF_MAP_LOW, rnd, EEL_RESP_OKAY);
        mapLo &= ~rnd;
        rdc(EEL_OFF_MAP_LOW, mapLo);
        wr(EEL_OFF_MAP_HIGH, ~rnd, EEL_RESP_OKAY);
        mapHi &= rnd;
        rdc(EEL_OFF_MAP_HIGH, mapHi);
        rdc(EEL_OFF_ADDR_FIFO, head());
        wr(EEL_OFF_ADDR_FIFO, 32'h3, EEL_RESP_OKAY);
        rdc(EEL_OFF_ADDR_FIFO, head());
        wr(EEL_OFF_ADDR_FIFO, EEL_POP_ONE, EEL_RESP_OKAY);
        void'(fifo.pop_front());
        rdc(EEL_OFF_ADDR_FIFO, head());
        rep(1'b1, 1'b0, 64'h1, xs());
        wr(EEL_OFF_ADDR_FIFO, EEL_POP_BOTH, EEL_RESP_OKAY);
        fifo.delete();
        rdc(EEL_OFF_ADDR_FIFO, head());
        rep(1'b0, 1'b1, 64'h0, xs());
        rep(1'b0, 1'b1, 64'h0, xs());
        rdc(EEL_OFF_DBL_ADDR, dbl);
        wr(EEL_OFF_DBL_ADDR, 32'h2, EEL_RESP_OKAY);
        rdc(EEL_OFF_DBL_ADDR, dbl);
        wr(EEL_OFF_DBL_ADDR, EEL_DBL_CLEAR, EEL_RESP_OKAY);
        dblV = 1'b0;
        rdc(EEL_OFF_DBL_ADDR, 32'h0);
        rep(1'b0, 1'b1, 64'h0, xs());
        rdc(EEL_OFF_DBL_ADDR, dbl);
        rdc(EEL_OFF_ERR_COUNT, cnt);
        // Empty the count so the threshold crossing lands on a known error
        wr(EEL_OFF_ERR_COUNT, cnt, EEL_RESP_OKAY);
        cnt = 32'h0;
        rdc(EEL_OFF_ERR_COUNT, 32'h0);
        wr(EEL_OFF_THRESHOLD, 32'h0200_0000, EEL_RESP_OKAY);
        rdc(EEL_OFF_IRQ_STATUS, 32'h3);
        for (int i = 0; i < 3; i++) begin
            rep(1'b1, 1'b0, 64'h1, xs());
            irqc(i == 2);
        end
        rdc(EEL_OFF_ERR_COUNT, cnt);
        rdc(EEL_OFF_IRQ_STATUS, 32'h5);
        irqc(1'b0);
        wrap_up();
    end
endmodule
